// ---- common/wdtu_regs.svh ----
`ifndef WDTU_REGS_SVH
`define WDTU_REGS_SVH
// ****************************************
// register byte addresses (index times four)
// ****************************************
`define WDTU_IDX_CLKSEL 8'h41
`define WDTU_IDX_PFLAGS 8'h97
`define WDTU_IDX_CTRL 8'he1
`define WDTU_IDX_SYSTEM_FLAG_IRQ_ENABLE_REG 8'h8e
`define WDTU_IDX_MODE 8'hf0
`define WDTU_ADR_CLKSEL 10'h104
`define WDTU_ADR_PFLAGS 10'h25c
`define WDTU_ADR_CTRL 10'h384
`define WDTU_ADR_SYSTEM_FLAG_IRQ_ENABLE_REG 10'h238
`define WDTU_ADR_MODE 10'h3c0
// ****************************************
// field positions
// ****************************************
`define WDTU_CTRL_RSTEN 7
`define WDTU_CTRL_NONSTOP 6
`define WDTU_CTRL_RUN 5
`define WDTU_CTRL_CLR 4
`define WDTU_CTRL_IDLE 3
`define WDTU_CLK_SRC_HI 7
`define WDTU_CLK_SRC_LO 6
`define WDTU_CLK_TAP 4
`define WDTU_MODE_PROT 0
`define WDTU_MODE_IDLE 1
`define WDTU_MODE_PDOWN 2
`define WDTU_MODE_GROUP 3
// ****************************************
// reset values and timing
// ****************************************
`define WDTU_CTRL_RST 8'h07
`define WDTU_CLKSEL_RST 8'h00
`define WDTU_SYSDIV 4'd12
`define WDTU_LATENCY_US 120
`define WDTU_SHORT_MS 12
`endif

// ---- common/wdtu_pkg.sv ----
// ****************************************
// shared types
// ****************************************
package wdtu_pkg;
	typedef enum logic [1:0] {
		WDTU_SRC_SLOW = 2'h0,
		WDTU_SRC_EXT = 2'h1,
		WDTU_SRC_SYS12 = 2'h2,
		WDTU_SRC_BAUD = 2'h3
	} wdtu_src_t;
	typedef enum logic [1:0] {
		WDTU_BUS_IDLE = 2'h0,
		WDTU_BUS_ACK = 2'h1
	} wdtu_bus_t;
endpackage : wdtu_pkg

// ---- hdl/wdtu_sync.sv ----
`timescale 1ns/1ps
// ****************************************
// two-stage synchroniser with edge pulse
// ****************************************
module wdtu_sync
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// async level in, pulse out
	input wire logic din,
	output logic rise
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	// first stage feeds only the second
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end
		else
		begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	assign rise = s2_r & ~s3_r;
endmodule : wdtu_sync

// ---- hdl/wdtu_top.sv ----
`timescale 1ns/1ps
`include "wdtu_regs.svh"
// Overview of operation
// - 8-bit counter behind 8-bit prescaler, one control
// - two-bit clock source select, slow RC default
// - overflow sets flag in power flags bit0
// - interrupt needs flag enable and group enable
// - reset-enable makes overflow cause system reset
// - writing one to clear bit zeroes counter
// - control bits 7..5 set-only except protected page
// - run bit cleared only by power-on/protected
// - control survives pin, software, watchdog reset
// - idle counting needs idle bit or nonstop fuse
// - nonstop bit keeps counting in power-down
// - watch mode only on slow or external clock
// - prescale code selects divide 2 to 256
// - tap bit picks bit-8 or bit-0 overflow
// - flag set by hardware, cleared writing one
// - slow clock adds about 120 us latency
// - auto-enable fuse loads control at power-up
// - auto-enable plus protect blocks control writes but clear
module wdtu_top
	import wdtu_pkg::*;
(
	// clock and resets
	input wire logic MCLK,
	input wire logic RESET,
	input wire logic SYS_RESET,
	// classic wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [9:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// watchdog clock sources
	input wire logic SLOW_OSC_IN,
	input wire logic EXT_CLK_IN,
	input wire logic BAUD_OVF_IN,
	// fuse options
	input wire logic FUSE_AUTO_ENABLE,
	input wire logic FUSE_WRITE_PROTECT,
	input wire logic FUSE_NONSTOP,
	input wire logic FUSE_RESET_ENABLE,
	input wire logic FUSE_IDLE_COUNT,
	input wire logic [2:0] FUSE_PRESCALE,
	// results
	output logic IRQ,
	output logic WDT_RESET_REQ,
	output logic WAKEUP
);
	// ****************************************
	// registers and wires
	// ****************************************
	logic [7:0] ctrl_r;
	logic [7:0] clksel_r;
	logic flag_r;
	logic flag_ie_r;
	logic [3:0] mode_r;
	logic [7:0] pre_r;
	logic [7:0] cnt_r;
	logic [3:0] sdiv_r;
	logic ack_r;
	logic [31:0] dat_r;
	logic por_load_r;
	logic ovf_r;
	logic slow_tick;
	logic ext_tick;
	logic baud_tick;
	logic sys_tick;
	logic src_tick;
	logic run;
	logic active;
	logic pre_tick;
	logic event_ovf;
	logic [7:0] pre_mask;
	// ****************************************
	// bus decode
	// ****************************************
	wire req = WB_CYC_I & WB_STB_I & ~ack_r;
	wire wr = req & WB_WE_I & WB_SEL_I[0];
	wire hit_ctrl = WB_ADR_I == `WDTU_ADR_CTRL;
	wire hit_clk = WB_ADR_I == `WDTU_ADR_CLKSEL;
	wire hit_flag = WB_ADR_I == `WDTU_ADR_PFLAGS;
	wire hit_ie = WB_ADR_I == `WDTU_ADR_SYSTEM_FLAG_IRQ_ENABLE_REG;
	wire hit_mode = WB_ADR_I == `WDTU_ADR_MODE;
	wire prot_page = mode_r[`WDTU_MODE_PROT];
	wire locked = FUSE_AUTO_ENABLE & FUSE_WRITE_PROTECT;
	wire [7:0] wd = WB_DAT_I[7:0];
	wire wr_ctrl = wr & hit_ctrl & ~locked;
	wire clr_strobe = wr & hit_ctrl & wd[`WDTU_CTRL_CLR];
	wire flag_clr = wr & hit_flag & wd[0];
	// set-only in normal page, free in protected page
	function automatic logic sticky_bit(input logic old, input logic nv, input logic prot);
		sticky_bit = prot ? nv : (old | nv);
	endfunction : sticky_bit
	// next control value
	wire [7:0] ctrl_nxt = {
		sticky_bit(ctrl_r[7], wd[7], prot_page),
		sticky_bit(ctrl_r[6], wd[6], prot_page),
		sticky_bit(ctrl_r[5], wd[5], prot_page),
		1'b0,
		wd[3:0]};
	// ****************************************
	// control register, reset only by power-on
	// ****************************************
	always_ff @(posedge MCLK or posedge RESET)
	begin
		if (RESET)
		begin
			ctrl_r <= `WDTU_CTRL_RST;
			clksel_r <= `WDTU_CLKSEL_RST;
			por_load_r <= 1'b1;
		end
		else if (por_load_r)
		begin
			por_load_r <= 1'b0;
			if (FUSE_AUTO_ENABLE)
				ctrl_r <= {FUSE_RESET_ENABLE, FUSE_NONSTOP, 1'b1, 1'b0,
					FUSE_IDLE_COUNT, FUSE_PRESCALE};
		end
		else
		begin
			if (wr_ctrl)
				ctrl_r <= ctrl_nxt;
			if (wr & hit_clk & prot_page)
				clksel_r <= {wd[7:2], 2'h0};
		end
	end
	// read mux; unmapped reads zero
	wire [7:0] rdata = hit_ctrl ? ctrl_r :
		hit_clk ? clksel_r :
		hit_flag ? {7'h0, flag_r} :
		hit_ie ? {7'h0, flag_ie_r} :
		hit_mode ? {4'h0, mode_r} : 8'h00;
	// ****************************************
	// flag, enables, mode and bus answer
	// ****************************************
	always_ff @(posedge MCLK or posedge RESET)
	begin
		if (RESET)
		begin
			flag_r <= 1'b0;
			flag_ie_r <= 1'b0;
			mode_r <= 4'h0;
			ack_r <= 1'b0;
			dat_r <= 32'h0;
		end
		else
		begin
			flag_r <= event_ovf | (flag_r & ~flag_clr);
			if (wr & hit_ie)
				flag_ie_r <= wd[0];
			if (wr & hit_mode)
				mode_r <= wd[3:0];
			ack_r <= req;
			if (req)
				dat_r <= {24'h0, rdata};
		end
	end
	assign WB_ACK_O = ack_r;
	assign WB_DAT_O = dat_r;
	// ****************************************
	// clock source selection
	// ****************************************
	wdtu_sync u_slow
	(
		.clk(MCLK),
		.rst(RESET),
		.din(SLOW_OSC_IN),
		.rise(slow_tick)
	); // sync adds tick latency
	wdtu_sync u_ext
	(
		.clk(MCLK),
		.rst(RESET),
		.din(EXT_CLK_IN),
		.rise(ext_tick)
	);
	wdtu_sync u_baud
	(
		.clk(MCLK),
		.rst(RESET),
		.din(BAUD_OVF_IN),
		.rise(baud_tick)
	);
	// system clock divided by twelve
	always_ff @(posedge MCLK or posedge RESET)
	begin
		if (RESET)
			sdiv_r <= 4'h0;
		else
			sdiv_r <= sys_tick ? 4'h0 : sdiv_r + 4'h1;
	end
	assign sys_tick = sdiv_r == (`WDTU_SYSDIV - 4'd1);
	wire wdtu_src_t src = wdtu_src_t'(clksel_r[`WDTU_CLK_SRC_HI:`WDTU_CLK_SRC_LO]);
	assign src_tick = (src == WDTU_SRC_SLOW) ? slow_tick :
		(src == WDTU_SRC_EXT) ? ext_tick :
		(src == WDTU_SRC_SYS12) ? sys_tick : baud_tick;
	// ****************************************
	// counting permission by power mode
	// ****************************************
	wire watch_ok = (src == WDTU_SRC_SLOW) | (src == WDTU_SRC_EXT);
	wire in_idle = mode_r[`WDTU_MODE_IDLE];
	wire in_pd = mode_r[`WDTU_MODE_PDOWN];
	wire idle_ok = ctrl_r[`WDTU_CTRL_IDLE] | FUSE_NONSTOP;
	wire pd_ok = ctrl_r[`WDTU_CTRL_NONSTOP] & watch_ok;
	assign run = ctrl_r[`WDTU_CTRL_RUN];
	assign active = run & (in_pd ? pd_ok : (in_idle ? idle_ok : 1'b1));
	// ****************************************
	// prescaler and counter
	// ****************************************
	assign pre_mask = 8'h01 << ctrl_r[2:0];
	assign pre_tick = active & src_tick & ((pre_r & pre_mask) == pre_mask)
		& (((pre_r & (pre_mask - 8'h01)) == (pre_mask - 8'h01)));
	always_ff @(posedge MCLK or posedge RESET)
	begin
		if (RESET)
		begin
			pre_r <= 8'h0;
			cnt_r <= 8'h0;
		end
		else if (!run)
		begin
			pre_r <= 8'h0;
			cnt_r <= 8'h0;
		end
		else
		begin
			if (active & src_tick)
				pre_r <= pre_tick ? 8'h0 : pre_r + 8'h1;
			if (clr_strobe)
				cnt_r <= 8'h0;
			else if (pre_tick)
				cnt_r <= cnt_r + 8'h1;
		end
	end
	// tap: full wrap or every counter step
	assign event_ovf = pre_tick & ~clr_strobe &
		(clksel_r[`WDTU_CLK_TAP] | (cnt_r == 8'hff));
	// ****************************************
	// results
	// ****************************************
	always_ff @(posedge MCLK or posedge RESET)
	begin
		if (RESET)
			ovf_r <= 1'b0;
		else
			ovf_r <= event_ovf;
	end
	wire irq_on = flag_r & flag_ie_r & mode_r[`WDTU_MODE_GROUP];
	assign IRQ = irq_on;
	assign WDT_RESET_REQ = ovf_r & ctrl_r[`WDTU_CTRL_RSTEN];
	assign WAKEUP = in_pd & (irq_on | WDT_RESET_REQ);
	// ****************************************
	// checks
	// ****************************************
	a_flag_sets: assert property (@(posedge MCLK) disable iff (RESET)
		event_ovf |=> flag_r) else $error("flag not set");
	a_irq_gate: assert property (@(posedge MCLK) disable iff (RESET)
		IRQ |-> flag_ie_r && mode_r[3]) else $error("irq without enables");
	a_reset_req: assert property (@(posedge MCLK) disable iff (RESET)
		event_ovf && ctrl_r[7] |=> WDT_RESET_REQ) else $error("no reset");
	a_clear_cnt: assert property (@(posedge MCLK) disable iff (RESET)
		clr_strobe && run |=> cnt_r == 8'h00) else $error("clear failed");
	a_run_sticky: assert property (@(posedge MCLK) disable iff (RESET)
		run && !prot_page && !por_load_r |=> run) else $error("run dropped");
	a_idle_hold: assert property (@(posedge MCLK) disable iff (RESET)
		run && !active |=> $stable(pre_r)) else $error("counted while held");
	a_stopped: assert property (@(posedge MCLK) disable iff (RESET)
		!run |=> cnt_r == 8'h00 && pre_r == 8'h00) else $error("not held");
	a_flag_clear: assert property (@(posedge MCLK) disable iff (RESET)
		flag_clr && !event_ovf |=> !flag_r) else $error("flag stuck");
	a_locked: assert property (@(posedge MCLK) disable iff (RESET)
		locked && !por_load_r |=> $stable(ctrl_r)) else $error("locked write");
	c_overflow: cover property (@(posedge MCLK) disable iff (RESET) event_ovf);
	c_reset: cover property (@(posedge MCLK) disable iff (RESET) WDT_RESET_REQ);
	c_wake: cover property (@(posedge MCLK) disable iff (RESET) WAKEUP);
endmodule : wdtu_top

// ---- verif/tb_wdtu_top.sv ----
`timescale 1ns/1ps
`include "wdtu_regs.svh"
module tb_wdtu_top;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic sys_rst = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [9:0] adr = 10'h000;
	logic [31:0] din = 32'h0;
	logic [31:0] dout;
	logic ack;
	logic [2:0] tk = 3'h0;
	logic f_auto = 1'b0;
	logic f_wp = 1'b0;
	logic f_ns = 1'b0;
	logic f_rst = 1'b0;
	logic f_idl = 1'b0;
	logic [2:0] f_ps = 3'h0;
	logic irq;
	logic rreq;
	logic wake;
	logic [7:0] rdv;
	int bad_count = 0;
	int samples_checked = 0;
	int rq = 0;
	// {address, write data, expected readback}
	logic [25:0] rows [0:9] = '{
		{10'h3c0, 8'h01, 8'h01}, {10'h104, 8'hd0, 8'hd0},
		{10'h384, 8'hf8, 8'he8}, {10'h384, 8'h00, 8'h00},
		{10'h238, 8'h01, 8'h01}, {10'h000, 8'hff, 8'h00},
		{10'h3c0, 8'h00, 8'h00}, {10'h104, 8'h00, 8'hd0},
		{10'h384, 8'he3, 8'he3}, {10'h384, 8'h04, 8'he4}};
	wdtu_top DUT (.MCLK(mclk), .RESET(reset), .SYS_RESET(sys_rst),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(4'h1), .WB_DAT_I(din), .WB_DAT_O(dout), .WB_ACK_O(ack),
		.SLOW_OSC_IN(tk[0]), .EXT_CLK_IN(tk[1]), .BAUD_OVF_IN(tk[2]),
		.FUSE_AUTO_ENABLE(f_auto), .FUSE_WRITE_PROTECT(f_wp),
		.FUSE_NONSTOP(f_ns), .FUSE_RESET_ENABLE(f_rst),
		.FUSE_IDLE_COUNT(f_idl), .FUSE_PRESCALE(f_ps),
		.IRQ(irq), .WDT_RESET_REQ(rreq), .WAKEUP(wake));
	// 50 ns clock
	always #25 mclk = ~mclk;
	// count reset request pulses
	always @(posedge mclk)
		if (rreq === 1'b1)
			rq++;
	task end_sim;
		if (bad_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e)
		begin
			$display("Error %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask : chk
	// one classic wishbone cycle, held until ack
	task wb(input logic w, input logic [9:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		din <= {24'h0, d};
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		rdv = dout[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 50)
		begin
			bad_count++;
			end_sim();
		end
	endtask : wb
	// source ticks on one line
	task tick(input int s, input int c);
		repeat (c)
		begin
			@(posedge mclk);
			tk[s] <= 1'b1;
			repeat (3) @(posedge mclk);
			tk[s] <= 1'b0;
			repeat (4) @(posedge mclk);
		end
	endtask : tick
	task flg(input logic e);
		repeat (6) @(posedge mclk);
		wb(1'b0, 10'h25c, 8'h00);
		chk("flag", {7'h0, e}, {7'h0, rdv[0]});
	endtask : flg
	initial
	begin
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		repeat (2) @(posedge mclk);
		wb(1'b0, 10'h384, 8'h00);
		chk("ctrl", 8'h07, rdv);
		wb(1'b0, 10'h104, 8'h00);
		chk("clksel", 8'h00, rdv);
		flg(1'b0);
		foreach (rows[i])
		begin
			wb(1'b1, rows[i][25:16], rows[i][15:8]);
			wb(1'b0, rows[i][25:16], 8'h00);
			chk("row", rows[i][7:0], rdv);
		end
		wb(1'b1, 10'h3c0, 8'h01);
		wb(1'b1, 10'h384, 8'h00);
		wb(1'b1, 10'h104, 8'h50);
		wb(1'b1, 10'h384, 8'h20);
		wb(1'b1, 10'h25c, 8'h01);
		tick(1, 4);
		flg(1'b1);
		chk("irq", 8'h00, {7'h0, irq});
		wb(1'b1, 10'h3c0, 8'h09);
		chk("irq", 8'h01, {7'h0, irq});
		wb(1'b1, 10'h3c0, 8'h0d);
		chk("wake", 8'h01, {7'h0, wake});
		wb(1'b1, 10'h3c0, 8'h09);
		wb(1'b1, 10'h25c, 8'h00);
		flg(1'b1);
		wb(1'b1, 10'h25c, 8'h01);
		flg(1'b0);
		wb(1'b1, 10'h104, 8'h10);
		tick(1, 8);
		flg(1'b0);
		tick(0, 4);
		flg(1'b1);
		wb(1'b1, 10'h384, 8'ha0);
		rq = 0;
		tick(0, 4);
		chk("rstreq", 8'h01, {7'h0, rq != 0});
		wb(1'b1, 10'h384, 8'h20);
		wb(1'b1, 10'h104, 8'h00);
		wb(1'b1, 10'h25c, 8'h01);
		repeat (5)
		begin
			tick(0, 200);
			wb(1'b1, 10'h384, 8'h30);
		end
		flg(1'b0);
		tick(0, 600);
		flg(1'b1);
		// idle: held without idle bit, counts with it
		wb(1'b1, 10'h104, 8'h10);
		wb(1'b1, 10'h25c, 8'h01);
		wb(1'b1, 10'h3c0, 8'h0b);
		tick(0, 4);
		flg(1'b0);
		wb(1'b1, 10'h384, 8'h28);
		tick(0, 4);
		flg(1'b1);
		// prescale code 2 divides by eight
		wb(1'b1, 10'h3c0, 8'h09);
		wb(1'b1, 10'h384, 8'h22);
		wb(1'b1, 10'h25c, 8'h01);
		tick(0, 7);
		flg(1'b0);
		tick(0, 1);
		flg(1'b1);
		// watch mode on slow clock wakes, not on divided clock
		wb(1'b1, 10'h25c, 8'h01);
		wb(1'b1, 10'h384, 8'h60);
		wb(1'b1, 10'h3c0, 8'h0d);
		tick(0, 2);
		chk("wake", 8'h01, {7'h0, wake});
		wb(1'b1, 10'h104, 8'h90);
		wb(1'b1, 10'h25c, 8'h01);
		repeat (40) @(posedge mclk);
		flg(1'b0);
		sys_rst <= 1'b1;
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		wb(1'b0, 10'h384, 8'h00);
		chk("ctrl", 8'h60, rdv);
		{f_auto, f_wp, f_rst, f_idl, f_ps} <= 7'h7d;
		reset <= 1'b1;
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		repeat (2) @(posedge mclk);
		wb(1'b0, 10'h384, 8'h00);
		chk("fusectrl", 8'had, rdv);
		wb(1'b1, 10'h3c0, 8'h01);
		wb(1'b1, 10'h384, 8'h00);
		wb(1'b0, 10'h384, 8'h00);
		chk("wpctrl", 8'had, rdv);
		end_sim();
	end
endmodule : tb_wdtu_top
